// File: bench/fan_drive_smoothing_and_routing_test.sv
// Self-checking bench for the fan drive smoothing and routing core.
// Assumes a filter tick of 8 clocks and the fan model on both outputs.
`timescale 1ns/1ps
`default_nettype none
module fan_drive_smoothing_and_routing_test;
   logic i_clock = 1'b0, i_srst = 1'b1, wr = 1'b0, rd = 1'b0, lz1, lz2, sp1, sp2;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, d1, d2, c1, c2, c3, c4, loop = 8'h00;
   logic [7:0] t1 = 8'h00, t2 = 8'h00, t3 = 8'h00, t4 = 8'h00;
   logic [7:0] z1 = 8'h11, z2 = 8'h22, z3 = 8'h33, z4 = 8'h44;
   logic [7:0] msk [4] = '{8'h77, 8'hf8, 8'hf8, 8'hff};
   int n_mismatch = 0, samples_checked = 0;
   always #25 i_clock = ~i_clock;
   fdsr_core #(.TICK_CYCLES(8)) i_dut (.i_clock(i_clock), .i_srst(i_srst), .i_addr(addr), .i_wdata(wdata),
      .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_curve_table_one_duty(t1), .i_curve_table_two_duty(t2),
      .i_curve_table_three_duty(t3), .i_curve_table_four_duty(t4), .i_loop_duty(loop), .i_zone1_temp(z1),
      .i_zone2_temp(z2), .i_zone3_temp(z3), .i_zone4_temp(z4), .o_fan_drive_first(d1), .o_fan_drive_second(d2),
      .o_loop_on_zone1(lz1), .o_loop_on_zone2(lz2), .o_curve_table_one_temp(c1), .o_curve_table_two_temp(c2),
      .o_curve_table_three_temp(c3), .o_curve_table_four_temp(c4));
   fdsr_fan_model i_fan (.i_clock(i_clock), .i_duty_first(d1), .i_duty_second(d2), .o_first_spinning(sp1),
      .o_second_spinning(sp2));
   task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clock);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge i_clock);
      wr <= 1'b0;
   endtask
   task rd_reg(input logic [7:0] a, input logic [7:0] exp);
      @(posedge i_clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge i_clock);
      rd <= 1'b0;
      #1 chk("register", exp, rdata);
   endtask
   // Filter settling has no handshake, so wait a bounded time for the window.
   task wait_first(input logic [7:0] lo, input logic [7:0] hi);
      for (int i = 0; i < 400 && !(d1 >= lo && d1 <= hi); i++) @(posedge i_clock) #1;
      chk("first drive", lo, (d1 >= lo && d1 <= hi) ? lo : d1);
   endtask
   task end_sim;
      $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge i_clock);
      i_srst <= 1'b0;
      for (int i = 0; i < 4; i++) rd_reg(8'h32 + i[7:0], (i == 3) ? 8'h30 : 8'h00);
      wr_reg(8'h36, 8'hff);
      rd_reg(8'h36, 8'h00);
      for (int i = 0; i < 4; i++) begin
         wr_reg(8'h32 + i[7:0], 8'hff);
         rd_reg(8'h32 + i[7:0], msk[i]);
      end
      for (int b = 0; b < 8; b++) begin
         wr_reg(8'h35, 8'h01 << b);
         repeat (2) @(posedge i_clock);
         #1 chk("zone1 loop", {7'h00, b == 0}, {7'h00, lz1});
         chk("zone2 loop", {7'h00, b == 1}, {7'h00, lz2});
         chk("table one", (b == 4) ? z1 : z3, c1);
         chk("table two", (b == 5) ? z2 : z4, c2);
         chk("table three", (b == 6) ? z1 : z3, c3);
         chk("table four", (b == 7) ? z2 : z4, c4);
      end
      wr_reg(8'h35, 8'h00);
      wr_reg(8'h32, 8'h00);
      @(posedge i_clock);
      t1 <= 8'h40;
      t2 <= 8'h20;
      t3 <= 8'h10;
      t4 <= 8'h50;
      wait_first(8'h40, 8'h40);
      chk("second drive", 8'h50, d2);
      wr_reg(8'h35, 8'h0c);
      loop <= 8'h90;
      wait_first(8'h90, 8'h90);
      chk("second drive", 8'h90, d2);
      wr_reg(8'h35, 8'h00);
      wr_reg(8'h33, 8'h40);
      wr_reg(8'h32, 8'h01);
      t1 <= 8'h30;
      t2 <= 8'h00;
      wait_first(8'h00, 8'h00);
      @(posedge i_clock) #1 chk("first fan", 8'h00, {7'h00, sp1});
      chk("second fan", 8'h01, {7'h00, sp2});
      @(posedge i_clock);
      t1 <= 8'h48;
      wait_first(8'h46, 8'h48);
      wr_reg(8'h33, 8'hf8);
      wait_first(8'h00, 8'h00);
      wr_reg(8'h32, 8'h10);
      wait_first(8'h48, 8'h48);
      @(posedge i_clock) #1 chk("second drive", 8'h00, d2);
      wr_reg(8'h33, 8'h00);
      wr_reg(8'h32, 8'h07);
      t1 <= 8'hc8;
      repeat (80) @(posedge i_clock);
      #1 chk("slow filter", 8'h01, {7'h00, d1 < 8'h60});
      wr_reg(8'h32, 8'h01);
      wait_first(8'hc6, 8'hc8);
      end_sim;
   end
endmodule // fan_drive_smoothing_and_routing_test
`default_nettype wire

// File: bench/fdsr_core_monitor.sv
// Checker for the register port and routing outputs of the core.
// Assumes it is bound to fdsr_core and sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module fdsr_core_monitor (
   input wire logic i_clock,
   input wire logic i_srst,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [7:0] o_rdata,
   input wire logic [7:0] i_zone1_temp,
   input wire logic [7:0] i_zone2_temp,
   input wire logic [7:0] i_zone3_temp,
   input wire logic [7:0] i_zone4_temp,
   input wire logic o_loop_on_zone1,
   input wire logic o_loop_on_zone2,
   input wire logic [7:0] o_curve_table_one_temp,
   input wire logic [7:0] o_curve_table_two_temp,
   input wire logic [7:0] o_curve_table_three_temp,
   input wire logic [7:0] o_curve_table_four_temp
);
   logic [7:0] route_reg;
   logic [7:0] route_d_reg;
   logic [1:0] up_reg;
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_srst);
   // Shadow of the routing byte; routing outputs are checked only once two edges follow reset.
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         route_reg <= 8'h30;
         route_d_reg <= 8'h30;
         up_reg <= 2'h0;
      end else begin
         if (i_wr && i_addr == 8'h35) route_reg <= i_wdata;
         route_d_reg <= route_reg;
         if (up_reg != 2'h2) up_reg <= up_reg + 2'h1;
      end
   end
   sequence s_route_wr;
      i_wr && i_addr == 8'h35;
   endsequence
   chk_read_idle: assert property (!i_rd |=> o_rdata == 8'h00)
      else $error("read data not idle");
   chk_unmapped_read: assert property (i_rd && (i_addr < 8'h32 || i_addr > 8'h35) |=> o_rdata == 8'h00)
      else $error("unmapped read not zero");
   chk_route_readback: assert property (s_route_wr ##2 (i_rd && i_addr == 8'h35) |=> o_rdata == $past(i_wdata, 3))
      else $error("routing readback wrong");
   chk_loop_zone1: assert property (up_reg == 2'h2 |-> o_loop_on_zone1 == route_d_reg[0])
      else $error("zone 1 binding wrong");
   chk_loop_zone2: assert property (up_reg == 2'h2 |-> o_loop_on_zone2 == route_d_reg[1])
      else $error("zone 2 binding wrong");
   chk_table_one_zone: assert property (up_reg == 2'h2 |->
      o_curve_table_one_temp == (route_d_reg[4] ? $past(i_zone1_temp) : $past(i_zone3_temp)))
      else $error("table one zone wrong");
   chk_table_two_zone: assert property (up_reg == 2'h2 |->
      o_curve_table_two_temp == (route_d_reg[5] ? $past(i_zone2_temp) : $past(i_zone4_temp)))
      else $error("table two zone wrong");
   chk_table_three_zone: assert property (up_reg == 2'h2 |->
      o_curve_table_three_temp == (route_d_reg[6] ? $past(i_zone1_temp) : $past(i_zone3_temp)))
      else $error("table three zone wrong");
   chk_table_four_zone: assert property (up_reg == 2'h2 |->
      o_curve_table_four_temp == (route_d_reg[7] ? $past(i_zone2_temp) : $past(i_zone4_temp)))
      else $error("table four zone wrong");
endmodule // fdsr_core_monitor
bind fdsr_core fdsr_core_monitor i_mon (.i_clock, .i_srst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
   .i_zone1_temp, .i_zone2_temp, .i_zone3_temp, .i_zone4_temp, .o_loop_on_zone1, .o_loop_on_zone2,
   .o_curve_table_one_temp, .o_curve_table_two_temp, .o_curve_table_three_temp, .o_curve_table_four_temp);
`default_nettype wire

// File: bench/fdsr_fan_model.sv
// Model of the fan drive circuitry behind the two outputs.
// Assumes duty words arrive as levels on the core clock.
`timescale 1ns/1ps
`default_nettype none
module fdsr_fan_model (
   input wire logic i_clock,
   input wire logic [7:0] i_duty_first,
   input wire logic [7:0] i_duty_second,
   output logic o_first_spinning,
   output logic o_second_spinning
);
   // A fan turns only while its drive word is above zero.
   always_ff @(posedge i_clock) begin
      o_first_spinning <= i_duty_first != 8'h00;
      o_second_spinning <= i_duty_second != 8'h00;
   end
endmodule // fdsr_fan_model
`default_nettype wire

// File: core/fdsr_core.sv
// Two-channel fan drive smoothing, low-duty cutoff while a channel's smoothing coefficient is non-zero, and source routing.
// Assumes synchronous inputs, a one-cycle register port and a single clock.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module fdsr_core #(
   parameter int TICK_CYCLES = fdsr_pkg::TICK_CYCLES
) (
   input wire logic i_clock,
   input wire logic i_srst,
   input wire logic [7:0] i_addr,
   input wire logic [fdsr_pkg::DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [fdsr_pkg::DATA_W-1:0] o_rdata,
   input wire logic [fdsr_pkg::DUTY_W-1:0] i_curve_table_one_duty,
   input wire logic [fdsr_pkg::DUTY_W-1:0] i_curve_table_two_duty,
   input wire logic [fdsr_pkg::DUTY_W-1:0] i_curve_table_three_duty,
   input wire logic [fdsr_pkg::DUTY_W-1:0] i_curve_table_four_duty,
   input wire logic [fdsr_pkg::DUTY_W-1:0] i_loop_duty,
   input wire logic [7:0] i_zone1_temp,
   input wire logic [7:0] i_zone2_temp,
   input wire logic [7:0] i_zone3_temp,
   input wire logic [7:0] i_zone4_temp,
   output logic [fdsr_pkg::DUTY_W-1:0] o_fan_drive_first,
   output logic [fdsr_pkg::DUTY_W-1:0] o_fan_drive_second,
   output logic o_loop_on_zone1,
   output logic o_loop_on_zone2,
   output logic [7:0] o_curve_table_one_temp,
   output logic [7:0] o_curve_table_two_temp,
   output logic [7:0] o_curve_table_three_temp,
   output logic [7:0] o_curve_table_four_temp
);

   localparam int ACC_W = fdsr_pkg::DUTY_W + fdsr_pkg::FRAC_W;
   localparam int CNT_W = $clog2(TICK_CYCLES + 1);
   localparam logic [CNT_W-1:0] TICK_LAST = CNT_W'(TICK_CYCLES - 1);

   function automatic logic [fdsr_pkg::DUTY_W-1:0] duty_max(
      input logic [fdsr_pkg::DUTY_W-1:0] a,
      input logic [fdsr_pkg::DUTY_W-1:0] b
   );
      return (a > b) ? a : b;
   endfunction

   // One IIR step: the accumulator moves by a 1/2^k share of the error.
   function automatic logic [ACC_W-1:0] iir_step(
      input logic [ACC_W-1:0] acc,
      input logic [fdsr_pkg::DUTY_W-1:0] x,
      input logic [fdsr_pkg::COEFF_W-1:0] k
   );
      logic signed [ACC_W:0] err;
      logic signed [ACC_W:0] sum;
      err = signed'({1'b0, x, {fdsr_pkg::FRAC_W{1'b0}}}) - signed'({1'b0, acc});
      sum = signed'({1'b0, acc}) + (err >>> k);
      return sum[ACC_W-1:0];
   endfunction

   // Register file.
   logic [7:0] smooth_reg, smooth_next;
   logic [7:0] cut1_reg, cut1_next;
   logic [7:0] cut2_reg, cut2_next;
   logic [7:0] route_reg, route_next;
   logic [7:0] rdata_reg, rdata_next;

   always_comb begin
      smooth_next = smooth_reg;
      cut1_next = cut1_reg;
      cut2_next = cut2_reg;
      route_next = route_reg;
      rdata_next = 8'h00;
      if (i_wr) begin
         unique case (i_addr)
            fdsr_pkg::ADDR_SMOOTH: smooth_next = i_wdata & fdsr_pkg::MASK_SMOOTH;
            fdsr_pkg::ADDR_CUT1: cut1_next = i_wdata & fdsr_pkg::MASK_CUT;
            fdsr_pkg::ADDR_CUT2: cut2_next = i_wdata & fdsr_pkg::MASK_CUT;
            fdsr_pkg::ADDR_ROUTE: route_next = i_wdata;
            default: begin
            end
         endcase
      end
      if (i_rd) begin
         unique case (i_addr)
            fdsr_pkg::ADDR_SMOOTH: rdata_next = smooth_reg;
            fdsr_pkg::ADDR_CUT1: rdata_next = cut1_reg;
            fdsr_pkg::ADDR_CUT2: rdata_next = cut2_reg;
            fdsr_pkg::ADDR_ROUTE: rdata_next = route_reg;
            default: rdata_next = 8'h00;
         endcase
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         smooth_reg <= fdsr_pkg::RST_SMOOTH;
         cut1_reg <= fdsr_pkg::RST_CUT;
         cut2_reg <= fdsr_pkg::RST_CUT;
         route_reg <= fdsr_pkg::RST_ROUTE;
         rdata_reg <= 8'h00;
      end else begin
         smooth_reg <= smooth_next;
         cut1_reg <= cut1_next;
         cut2_reg <= cut2_next;
         route_reg <= route_next;
         rdata_reg <= rdata_next;
      end
   end

   // Filter update tick; every smoothing step waits for it.
   logic [CNT_W-1:0] tick_cnt_reg, tick_cnt_next;
   logic tick_reg, tick_next;

   always_comb begin
      tick_next = 1'b0;
      tick_cnt_next = tick_cnt_reg + CNT_W'(1);
      if (tick_cnt_reg == TICK_LAST) begin
         tick_cnt_next = '0;
         tick_next = 1'b1;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         tick_cnt_reg <= '0;
         tick_reg <= 1'b0;
      end else begin
         tick_cnt_reg <= tick_cnt_next;
         tick_reg <= tick_next;
      end
   end

   // Smoothing and cutoff, one channel per fan drive output.
   logic [ACC_W-1:0] acc_reg [2];
   logic [ACC_W-1:0] acc_next [2];
   logic [fdsr_pkg::DUTY_W-1:0] duty_reg [2];
   logic [fdsr_pkg::DUTY_W-1:0] duty_next [2];

   always_comb begin
      logic [fdsr_pkg::DUTY_W-1:0] src;
      logic [fdsr_pkg::DUTY_W-1:0] smooth;
      logic [fdsr_pkg::DUTY_W-1:0] cmd;
      logic [fdsr_pkg::COEFF_W-1:0] coeff;
      logic [fdsr_pkg::CUT_W-1:0] cut;
      logic [fdsr_pkg::THR_W-1:0] thr;
      logic follows;
      src = '0;
      smooth = '0;
      cmd = '0;
      coeff = '0;
      cut = '0;
      thr = '0;
      follows = 1'b0;
      for (int c = 0; c < 2; c++) begin
         if (c == 0) begin
            src = duty_max(i_curve_table_one_duty, i_curve_table_two_duty);
            coeff = smooth_reg[fdsr_pkg::COEFF1_LSB +: fdsr_pkg::COEFF_W];
            cut = cut1_reg[fdsr_pkg::CUT_LSB +: fdsr_pkg::CUT_W];
            follows = route_reg[fdsr_pkg::BIT_OUT1_LOOP];
         end else begin
            src = duty_max(i_curve_table_three_duty, i_curve_table_four_duty);
            coeff = smooth_reg[fdsr_pkg::COEFF2_LSB +: fdsr_pkg::COEFF_W];
            cut = cut2_reg[fdsr_pkg::CUT_LSB +: fdsr_pkg::CUT_W];
            follows = route_reg[fdsr_pkg::BIT_OUT2_LOOP];
         end
         // A bypassed filter tracks its input so that enabling it starts without a jump.
         acc_next[c] = acc_reg[c];
         if (coeff == '0) begin
            acc_next[c] = {src, {fdsr_pkg::FRAC_W{1'b0}}};
            smooth = src;
         end else begin
            if (tick_reg) begin
               acc_next[c] = iir_step(acc_reg[c], src, coeff);
            end
            smooth = acc_reg[c][ACC_W-1 -: fdsr_pkg::DUTY_W];
         end
         cmd = follows ? duty_max(smooth, i_loop_duty) : smooth;
         thr = {1'b0, cut, {fdsr_pkg::CUT_SHIFT{1'b0}}};
         if ((coeff != '0) && ({1'b0, cmd} < thr)) begin
            duty_next[c] = '0;
         end else begin
            duty_next[c] = cmd;
         end
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         for (int c = 0; c < 2; c++) begin
            acc_reg[c] <= '0;
            duty_reg[c] <= '0;
         end
      end else begin
         for (int c = 0; c < 2; c++) begin
            acc_reg[c] <= acc_next[c];
            duty_reg[c] <= duty_next[c];
         end
      end
   end

   assign o_fan_drive_first = duty_reg[0];
   assign o_fan_drive_second = duty_reg[1];
   assign o_rdata = rdata_reg;

   // Zone routing for the loop and the curve tables.
   logic loop_z1_reg, loop_z1_next;
   logic loop_z2_reg, loop_z2_next;
   logic [7:0] tab1_reg, tab1_next;
   logic [7:0] tab2_reg, tab2_next;
   logic [7:0] tab3_reg, tab3_next;
   logic [7:0] tab4_reg, tab4_next;

   always_comb begin
      loop_z1_next = route_reg[fdsr_pkg::BIT_LOOP_Z1];
      loop_z2_next = route_reg[fdsr_pkg::BIT_LOOP_Z2];
      tab1_next = route_reg[fdsr_pkg::BIT_TAB1_Z1] ? i_zone1_temp : i_zone3_temp;
      tab2_next = route_reg[fdsr_pkg::BIT_TAB2_Z2] ? i_zone2_temp : i_zone4_temp;
      tab3_next = route_reg[fdsr_pkg::BIT_TAB3_Z1] ? i_zone1_temp : i_zone3_temp;
      tab4_next = route_reg[fdsr_pkg::BIT_TAB4_Z2] ? i_zone2_temp : i_zone4_temp;
   end

   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         loop_z1_reg <= 1'b0;
         loop_z2_reg <= 1'b0;
         tab1_reg <= 8'h00;
         tab2_reg <= 8'h00;
         tab3_reg <= 8'h00;
         tab4_reg <= 8'h00;
      end else begin
         loop_z1_reg <= loop_z1_next;
         loop_z2_reg <= loop_z2_next;
         tab1_reg <= tab1_next;
         tab2_reg <= tab2_next;
         tab3_reg <= tab3_next;
         tab4_reg <= tab4_next;
      end
   end

   assign o_loop_on_zone1 = loop_z1_reg;
   assign o_loop_on_zone2 = loop_z2_reg;
   assign o_curve_table_one_temp = tab1_reg;
   assign o_curve_table_two_temp = tab2_reg;
   assign o_curve_table_three_temp = tab3_reg;
   assign o_curve_table_four_temp = tab4_reg;

endmodule // fdsr_core

`default_nettype wire

// File: core/fdsr_pkg.sv
// Constants for the fan drive smoothing and routing stage.
// Assumes an 8-bit register port and 8-bit duty words on one 20 MHz clock.
package fdsr_pkg;
   localparam int DATA_W = 8;
   localparam int DUTY_W = 8;
   localparam int THR_W = 9;
   localparam int FRAC_W = 7;
   localparam int COEFF_W = 3;
   localparam int CUT_W = 5;
   localparam int CUT_SHIFT = 3;

   localparam logic [7:0] ADDR_SMOOTH = 8'h32;
   localparam logic [7:0] ADDR_CUT1 = 8'h33;
   localparam logic [7:0] ADDR_CUT2 = 8'h34;
   localparam logic [7:0] ADDR_ROUTE = 8'h35;

   localparam logic [7:0] RST_SMOOTH = 8'h00;
   localparam logic [7:0] RST_CUT = 8'h00;
   localparam logic [7:0] RST_ROUTE = 8'h30;

   localparam logic [7:0] MASK_SMOOTH = 8'h77;
   localparam logic [7:0] MASK_CUT = 8'hf8;

   localparam int COEFF1_LSB = 0;
   localparam int COEFF2_LSB = 4;
   localparam int CUT_LSB = 3;

   localparam int BIT_LOOP_Z1 = 0;
   localparam int BIT_LOOP_Z2 = 1;
   localparam int BIT_OUT1_LOOP = 2;
   localparam int BIT_OUT2_LOOP = 3;
   localparam int BIT_TAB1_Z1 = 4;
   localparam int BIT_TAB2_Z2 = 5;
   localparam int BIT_TAB3_Z1 = 6;
   localparam int BIT_TAB4_Z2 = 7;

   localparam int CLOCK_HZ = 20000000;
   localparam int TICK_US = 16000;
   localparam int TICK_CYCLES = (CLOCK_HZ / 1000000) * TICK_US;
endpackage : fdsr_pkg
